// File: hw/csc_pkg.sv
// constants and field layout for the clock synthesizer control block
// assumes a 16-bit register port and a 20 MHz core clock
package csc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  SYNTH_CTRL_ADDR      = 4'h0;
  localparam logic [3:0]  PIN_ASSIGN_ONE_ADDR  = 4'h2;
  localparam logic [15:0] SYNTH_CTRL_RESET     = 16'h3f00;
  localparam logic [15:0] PIN_ASSIGN_ONE_RESET = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ        = 16'h0000;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       vco_speed;
    logic       prescale;
    logic [5:0] fb_divider;
    logic       bus_div_sel;
    logic [1:0] zero_pad;
    logic       limp_flag;
    logic       lock_flag;
    logic       reset_on_loss;
    logic       stop_sim_clk;
    logic       stop_ext_clk;
  } csc_synth_ctrl_t;

  typedef struct packed {
    logic [13:0] other_fields;
    logic [1:0]  bus_clock_pin_assign_field;
  } csc_pin_assign_t;

  localparam logic [1:0] BUS_CLOCK_FUNC = 2'b10;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0] LOCK_REF_EDGES   = 8'h10;
  localparam logic [3:0] BUS_HALF_DIV8    = 4'h3;
  localparam logic [3:0] BUS_HALF_DIV16   = 4'h7;
  localparam logic [2:0] VCO_PER_SYS_DIV  = 3'h4;
  localparam logic [2:0] VCO_PER_SYS_BYP  = 3'h2;
  localparam logic [1:0] FB_BASE_SHIFT    = 2'h2;
  localparam logic [11:0] EXT_MULTIPLIER  = 12'h001;

  typedef enum {
    LOCK_EXTERNAL,
    LOCK_ACQUIRE,
    LOCK_HELD
  } csc_lock_state_t;

endpackage : csc_pkg

// File: hw/csc_top.sv
// control logic of the system clock generator: source select, frequency
// programming, lock tracking, power-up reset hold and slow bus clock
// assumes the analog loop sits outside and follows the programmed outputs
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module csc_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_clock_mode_pin,
  input  wire logic        i_reference_input_pin,
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [15:0] o_reg_rdata,
  output logic             o_synth_enable,
  output logic             o_vco_speed,
  output logic             o_post_divide_bypass,
  output logic      [6:0]  o_fb_modulus,
  output logic      [2:0]  o_vco_to_sys_ratio,
  output logic      [11:0] o_freq_multiplier,
  output logic             o_synth_lock,
  output logic             o_internal_reset,
  output logic             o_slow_bus_clock,
  output logic             o_top_address_pin_out,
  output logic             o_top_address_pin_oe
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ref_sync;
  logic       mode_filt;
  logic       ref_filt;
  logic       ref_filt_d;
  logic       ref_edge;

  // reset level matches an idle-low reference, so release brings no false edge
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ref_sync <= 3'h0;
    end else begin
      ref_sync <= {ref_sync[1:0], i_reference_input_pin};
    end
  end

  // mode pin is sampled inside reset, so its chain keeps running there
  logic [2:0] mode_chain;
  always_ff @(posedge i_core_clk) begin
    mode_chain <= {mode_chain[1:0], i_clock_mode_pin};
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge i_core_clk) begin
    if (mode_chain[1] == mode_chain[2]) begin
      mode_filt <= mode_chain[2];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ref_filt   <= 1'b0;
      ref_filt_d <= 1'b0;
      ref_edge   <= 1'b0;
    end else begin
      if (ref_sync[1] == ref_sync[2]) begin
        ref_filt <= ref_sync[2];
      end
      ref_filt_d <= ref_filt;
      ref_edge   <= ref_filt & ~ref_filt_d;
    end
  end

  // ----------------------------------------------------------------
  // clock source latch
  // ----------------------------------------------------------------
  logic synth_mode;

  // tracks the pin throughout reset, frozen from the release onward
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      synth_mode <= mode_filt;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  csc_pkg::csc_synth_ctrl_t ctrl;
  csc_pkg::csc_synth_ctrl_t wr_ctrl;
  csc_pkg::csc_pin_assign_t pin_assign;
  logic                     wrote_once;
  logic                     ctrl_wr;
  logic                     pin_wr;
  logic                     fb_changed;

  assign wr_ctrl    = csc_pkg::csc_synth_ctrl_t'(i_reg_wdata);
  assign ctrl_wr    = i_reg_wr & addr_hit(i_reg_addr, csc_pkg::SYNTH_CTRL_ADDR);
  assign pin_wr     = i_reg_wr & addr_hit(i_reg_addr, csc_pkg::PIN_ASSIGN_ONE_ADDR);
  // prescale is outside the loop, so only W and Y disturb the comparator
  assign fb_changed = ctrl_wr & ((wr_ctrl.vco_speed != ctrl.vco_speed) |
                                 (wr_ctrl.fb_divider != ctrl.fb_divider));

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl <= csc_pkg::csc_synth_ctrl_t'(csc_pkg::SYNTH_CTRL_RESET);
    end else if (ctrl_wr) begin
      ctrl.vco_speed     <= wr_ctrl.vco_speed;
      ctrl.prescale      <= wr_ctrl.prescale;
      ctrl.fb_divider    <= wr_ctrl.fb_divider;
      ctrl.bus_div_sel   <= wr_ctrl.bus_div_sel;
      ctrl.reset_on_loss <= wr_ctrl.reset_on_loss;
      ctrl.stop_sim_clk  <= wr_ctrl.stop_sim_clk;
      ctrl.stop_ext_clk  <= wr_ctrl.stop_ext_clk;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wrote_once <= 1'b0;
    end else if (ctrl_wr) begin
      wrote_once <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pin_assign <= csc_pkg::csc_pin_assign_t'(csc_pkg::PIN_ASSIGN_ONE_RESET);
    end else if (pin_wr) begin
      pin_assign <= csc_pkg::csc_pin_assign_t'(i_reg_wdata);
    end
  end

  // ----------------------------------------------------------------
  // lock tracking
  // ----------------------------------------------------------------
  csc_pkg::csc_lock_state_t lock_state;
  logic [7:0]               ref_count;

  // the loop is modelled by counting reference edges after any disturbance
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lock_state <= csc_pkg::LOCK_ACQUIRE;
      ref_count  <= 8'h00;
    end else begin
      case (lock_state)
        csc_pkg::LOCK_EXTERNAL: begin
          ref_count <= 8'h00;
        end
        csc_pkg::LOCK_ACQUIRE: begin
          if (!synth_mode) begin
            lock_state <= csc_pkg::LOCK_EXTERNAL;
          end else if (fb_changed) begin
            // a new ratio mid-acquire restarts the count, never locks on a stale one
            ref_count <= 8'h00;
          end else if (ref_edge) begin
            if (ref_count == csc_pkg::LOCK_REF_EDGES - 8'h01) begin
              lock_state <= csc_pkg::LOCK_HELD;
              ref_count  <= 8'h00;
            end else begin
              ref_count <= ref_count + 8'h01;
            end
          end
        end
        csc_pkg::LOCK_HELD: begin
          if (fb_changed) begin
            lock_state <= csc_pkg::LOCK_ACQUIRE;
            ref_count  <= 8'h00;
          end
        end
        default: begin
          lock_state <= csc_pkg::LOCK_ACQUIRE;
          ref_count  <= 8'h00;
        end
      endcase
    end
  end

  logic lock_view;
  // before the first write the flag is not yet meaningful and reads one
  always_comb begin
    lock_view = 1'b1;
    if (synth_mode && wrote_once) begin
      lock_view = (lock_state == csc_pkg::LOCK_HELD);
    end
  end

  // same edge as read data, so the pin and read bit 3 always agree
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_synth_lock <= 1'b0;
    end else begin
      o_synth_lock <= lock_view;
    end
  end

  // ----------------------------------------------------------------
  // power-up reset hold
  // ----------------------------------------------------------------
  // once released, later relocks do not pull the chip back into reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_internal_reset <= 1'b1;
    end else if (lock_state != csc_pkg::LOCK_ACQUIRE) begin
      o_internal_reset <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // frequency programming outputs
  // ----------------------------------------------------------------
  localparam csc_pkg::csc_synth_ctrl_t CTRL_AT_RESET = csc_pkg::csc_synth_ctrl_t'(csc_pkg::SYNTH_CTRL_RESET);
  // idle modulus follows the reset divider, so external mode parks the loop there
  localparam logic [6:0] IDLE_MODULUS = {1'b0, CTRL_AT_RESET.fb_divider} + 7'h01;

  logic [11:0] next_multiplier;
  logic [6:0]  fb_mod;
  logic [2:0]  mult_shift;

  assign fb_mod = {1'b0, ctrl.fb_divider} + 7'h01;
  // shift reaches five with W and X set: three bits, or the top ratios wrap
  assign mult_shift = {1'b0, csc_pkg::FB_BASE_SHIFT} + {1'b0, ctrl.vco_speed, 1'b0} + {2'b00, ctrl.prescale};

  always_comb begin
    next_multiplier = csc_pkg::EXT_MULTIPLIER;
    if (synth_mode) begin
      next_multiplier = {5'h00, fb_mod} << mult_shift;
    end
  end

  // external mode forces every synthesizer control to its idle value
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_synth_enable       <= 1'b0;
      o_vco_speed          <= 1'b0;
      o_post_divide_bypass <= 1'b0;
      o_fb_modulus         <= IDLE_MODULUS;
      o_vco_to_sys_ratio   <= csc_pkg::VCO_PER_SYS_DIV;
      o_freq_multiplier    <= csc_pkg::EXT_MULTIPLIER;
    end else begin
      o_synth_enable       <= synth_mode;
      o_vco_speed          <= synth_mode & ctrl.vco_speed;
      o_post_divide_bypass <= synth_mode & ctrl.prescale;
      o_fb_modulus         <= synth_mode ? fb_mod : IDLE_MODULUS;
      o_vco_to_sys_ratio   <= (synth_mode && ctrl.prescale) ? csc_pkg::VCO_PER_SYS_BYP
                                                           : csc_pkg::VCO_PER_SYS_DIV;
      o_freq_multiplier    <= next_multiplier;
    end
  end

  // ----------------------------------------------------------------
  // slow bus clock
  // ----------------------------------------------------------------
  logic [3:0] bus_cnt;
  logic [3:0] bus_half;
  logic       next_bus_clk;
  logic       pin_selected;

  assign bus_half     = ctrl.bus_div_sel ? csc_pkg::BUS_HALF_DIV16 : csc_pkg::BUS_HALF_DIV8;
  assign next_bus_clk = (bus_cnt >= bus_half) ? ~o_slow_bus_clock : o_slow_bus_clock;
  assign pin_selected = (pin_assign.bus_clock_pin_assign_field == csc_pkg::BUS_CLOCK_FUNC);

  // >= rather than == so a ratio change mid-period cannot overrun
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      bus_cnt          <= 4'h0;
      o_slow_bus_clock <= 1'b0;
    end else begin
      bus_cnt          <= (bus_cnt >= bus_half) ? 4'h0 : bus_cnt + 4'h1;
      o_slow_bus_clock <= next_bus_clk;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_top_address_pin_out <= 1'b0;
      o_top_address_pin_oe  <= 1'b0;
    end else begin
      o_top_address_pin_out <= pin_selected & next_bus_clk;
      o_top_address_pin_oe  <= pin_selected;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  csc_pkg::csc_synth_ctrl_t ctrl_view;
  logic                     ctrl_rd;
  logic                     pin_rd;

  assign ctrl_rd = i_reg_rd & addr_hit(i_reg_addr, csc_pkg::SYNTH_CTRL_ADDR);
  assign pin_rd  = i_reg_rd & addr_hit(i_reg_addr, csc_pkg::PIN_ASSIGN_ONE_ADDR);

  // limp detection is not built, so its flag and the pad bits read zero
  always_comb begin
    ctrl_view           = ctrl;
    ctrl_view.zero_pad  = 2'h0;
    ctrl_view.limp_flag = 1'b0;
    ctrl_view.lock_flag = lock_view;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_reg_rdata <= csc_pkg::UNMAPPED_READ;
    end else if (ctrl_rd) begin
      o_reg_rdata <= 16'(ctrl_view);
    end else if (pin_rd) begin
      o_reg_rdata <= 16'(pin_assign);
    end else begin
      o_reg_rdata <= csc_pkg::UNMAPPED_READ;
    end
  end

endmodule : csc_top

`default_nettype wire

// File: dv/csc_ref_src.sv
// free running reference square wave for the reference input pin
// assumes nothing of the core clock: its phase and period are unrelated to it
`timescale 1ns/100ps
`default_nettype none

module csc_ref_src #(
  parameter int HALF_NS = 190
) (
  output logic o_ref
);
  // not a multiple of the core period, so edges drift through the filter
  initial begin
    o_ref = 1'b0;
    forever #(HALF_NS) o_ref = ~o_ref;
  end
endmodule : csc_ref_src

`default_nettype wire

// File: dv/csc_top_assertions.sv
// port-level checker for the clock synthesizer control block
// assumes it is bound into csc_top and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none

module csc_top_assertions (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic [3:0]  i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [15:0] o_reg_rdata,
  input wire logic        o_synth_enable,
  input wire logic        o_vco_speed,
  input wire logic        o_post_divide_bypass,
  input wire logic [6:0]  o_fb_modulus,
  input wire logic [2:0]  o_vco_to_sys_ratio,
  input wire logic [11:0] o_freq_multiplier,
  input wire logic        o_synth_lock,
  input wire logic        o_internal_reset,
  input wire logic        o_slow_bus_clock,
  input wire logic        o_top_address_pin_out,
  input wire logic        o_top_address_pin_oe
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_lock_mirror; i_reg_rd && i_reg_addr == csc_pkg::SYNTH_CTRL_ADDR |=> o_reg_rdata[3] == o_synth_lock; endproperty
  a_lock_mirror: assert property (p_lock_mirror) else $error("lock bit read differs from lock output");
  // first edge after release still sees reset values, hence the guard
  property p_ext_lock; !$past(i_rst) && !o_synth_enable |-> o_synth_lock; endproperty
  a_ext_lock: assert property (p_ext_lock) else $error("lock low with external clock");
  property p_ext_forced;
    !o_synth_enable |-> !o_vco_speed && !o_post_divide_bypass && o_freq_multiplier == 12'h001
                        && o_vco_to_sys_ratio == 3'h4 && o_fb_modulus == 7'h40;
  endproperty
  a_ext_forced: assert property (p_ext_forced) else $error("control bits acted in external mode");
  property p_mult;
    o_synth_enable |-> o_freq_multiplier == (12'(o_fb_modulus) << (2 + 2 * o_vco_speed + o_post_divide_bypass));
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier wrong");
  property p_ratio; o_synth_enable |-> o_vco_to_sys_ratio == (o_post_divide_bypass ? 3'h2 : 3'h4); endproperty
  a_ratio: assert property (p_ratio) else $error("vco ratio wrong");
  property p_modulus;
    i_reg_wr && i_reg_addr == csc_pkg::SYNTH_CTRL_ADDR && o_synth_enable
      |-> ##2 o_fb_modulus == 7'($past(i_reg_wdata[13:8], 2)) + 7'h01;
  endproperty
  a_modulus: assert property (p_modulus) else $error("modulus not divider plus one");
  property p_pin; o_top_address_pin_out == (o_top_address_pin_oe & o_slow_bus_clock); endproperty
  a_pin: assert property (p_pin) else $error("bus clock pin wrong");
  property p_int_rst; !o_internal_reset |=> !o_internal_reset; endproperty
  a_int_rst: assert property (p_int_rst) else $error("internal reset came back");
  property p_mode_held; !$past(i_rst) && !$past(i_rst, 2) |-> $stable(o_synth_enable); endproperty
  a_mode_held: assert property (p_mode_held) else $error("mode changed outside reset");

  c_relock: cover property ($fell(o_synth_lock));
  c_rst_drop: cover property ($fell(o_internal_reset));
  c_pin_on: cover property ($rose(o_top_address_pin_oe));
endmodule : csc_top_assertions

bind csc_top csc_top_assertions u_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_synth_enable(o_synth_enable),
  .o_vco_speed(o_vco_speed), .o_post_divide_bypass(o_post_divide_bypass), .o_fb_modulus(o_fb_modulus),
  .o_vco_to_sys_ratio(o_vco_to_sys_ratio), .o_freq_multiplier(o_freq_multiplier), .o_synth_lock(o_synth_lock),
  .o_internal_reset(o_internal_reset), .o_slow_bus_clock(o_slow_bus_clock),
  .o_top_address_pin_out(o_top_address_pin_out), .o_top_address_pin_oe(o_top_address_pin_oe)
);

`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the clock synthesizer control block
// assumes csc_top, csc_pkg and the reference source model are compiled first
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        mode_pin = 1'b1;
  logic [3:0]  addr     = 4'h0;
  logic [15:0] wdata    = 16'h0000;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        ref_pin;
  logic [15:0] rdata;
  logic        synth_en, vco_speed, bypass, lock, int_rst, bus_clk, pin_out, pin_oe;
  logic [6:0]  modulus;
  logic [2:0]  ratio;
  logic [11:0] mult;
  logic [15:0] rv;
  int          n_errors = 0;
  int          checks   = 0;
  int          cyc      = 0;
  int          n;
  localparam logic [3:0] SC = csc_pkg::SYNTH_CTRL_ADDR;
  localparam logic [3:0] PA = csc_pkg::PIN_ASSIGN_ONE_ADDR;

  always #25 core_clk = ~core_clk;

  csc_ref_src u_ref (.o_ref(ref_pin));

  csc_top dut (
    .i_core_clk(core_clk), .i_rst(rst), .i_clock_mode_pin(mode_pin), .i_reference_input_pin(ref_pin),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .o_synth_enable(synth_en), .o_vco_speed(vco_speed), .o_post_divide_bypass(bypass),
    .o_fb_modulus(modulus), .o_vco_to_sys_ratio(ratio), .o_freq_multiplier(mult), .o_synth_lock(lock),
    .o_internal_reset(int_rst), .o_slow_bus_clock(bus_clk), .o_top_address_pin_out(pin_out),
    .o_top_address_pin_oe(pin_oe)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : step

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // mode pin settles through the filter before release
  task automatic reset_dut(input logic m);
    @(posedge core_clk);
    mode_pin <= m;
    rst      <= 1'b1;
    repeat (6) @(posedge core_clk);
    rst      <= 1'b0;
  endtask : reset_dut

  // first toggle only aligns; the second interval is returned
  task automatic half_period(output int h);
    logic v;
    v = pin_out;
    h = 0;
    while (pin_out === v && h < 40) begin
      step(1);
      h++;
    end
    v = pin_out;
    h = 0;
    while (pin_out === v && h < 40) begin
      step(1);
      h++;
    end
  endtask : half_period

  task automatic wait_lock();
    n = 0;
    while (lock !== 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
  endtask : wait_lock

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    reset_dut(1'b1);
    step(2);
    chk({15'h0000, int_rst}, 16'h0001);
    chk({15'h0000, synth_en}, 16'h0001);
    chk({9'h000, modulus}, 16'h0040);
    n = 0;
    while (int_rst !== 1'b0 && n < 2000) begin
      step(1);
      n++;
    end
    chk({15'h0000, n > 90}, 16'h0001);
    rd_reg(SC, rv);
    chk(rv, 16'h3f08);
    $display("test bringup done");
    wr_reg(SC, 16'h7f80);
    rd_reg(SC, rv);
    chk(rv, 16'h7f88);
    chk({12'h000, bypass, ratio}, 16'h000a);
    chk({4'h0, mult}, 16'h0200);
    wr_reg(SC, 16'h8300);
    rd_reg(SC, rv);
    chk(rv, 16'h8300);
    chk({4'h0, mult}, 16'h0040);
    chk({9'h000, modulus}, 16'h0004);
    wait_lock();
    rd_reg(SC, rv);
    chk(rv, 16'h8308);
    chk({15'h0000, int_rst}, 16'h0000);
    $display("test relock done");
    wr_reg(PA, 16'h0002);
    step(2);
    chk({15'h0000, pin_oe}, 16'h0001);
    half_period(n);
    chk(16'(n), 16'h0004);
    wr_reg(SC, 16'h8380);
    half_period(n);
    half_period(n);
    chk(16'(n), 16'h0008);
    rd_reg(SC, rv);
    chk(rv, 16'h8388);
    wr_reg(PA, 16'h0000);
    step(2);
    chk({14'h0000, pin_oe, pin_out}, 16'h0000);
    rv[0] = bus_clk;
    step(8);
    chk({15'h0000, bus_clk ^ rv[0]}, 16'h0001);
    wr_reg(4'h5, 16'hffff);
    rd_reg(4'h5, rv);
    chk(rv, 16'h0000);
    rd_reg(PA, rv);
    chk(rv, 16'h0000);
    $display("test bus clock done");
    reset_dut(1'b0);
    step(1);
    chk({15'h0000, int_rst}, 16'h0001);
    step(1);
    chk({14'h0000, int_rst, synth_en}, 16'h0000);
    wr_reg(SC, 16'hc3ff);
    rd_reg(SC, rv);
    chk(rv, 16'hc38f);
    chk({3'h0, vco_speed, mult}, 16'h0001);
    chk({9'h000, modulus}, 16'h0040);
    @(posedge core_clk);
    mode_pin <= 1'b1;
    step(8);
    chk({15'h0000, synth_en}, 16'h0000);
    $display("test external done");
    summarize();
  end
endmodule : tb

`default_nettype wire
